// file: bbc_pkg.sv
// Purpose: constants, register layouts and reset values of the backlight core
// Assumes: AHB-Lite word accesses, hclk at 10 MHz
// Notes: each configuration register holds one packed struct in its low bits
// What this block does
// - boost control timing is taken from the core clock
// - frequency code 00/01/10 picks 312/625/1250 kHz unless resistor select is set
// - adaptive loop raises setpoint when any watched string is under headroom
// - adaptive loop lowers setpoint when a string exceeds headroom plus hysteresis and no watched string is under headroom
// - raise and lower use their own configurable step sizes
// - setpoint code is the loop start value and its floor
// - setpoint never goes above the ceiling field
// - only strings enabled in the pattern are compared
// - adaptive bit 1 selects the adaptive loop, 0 selects manual setpoint
// - manual setpoint is range minimum plus 0.42 V per code step, within limits
// - one to three switch drivers, second and third set by enable bits
// - source field picks PWM only, PWM times register, or register only
// - passthrough bit 7 drives outputs straight from the PWM input
// - PWM input duty is measured as a 16-bit brightness value
// - source 01 multiplies duty by the brightness level before shaping
// - source 10 feeds the brightness level to the shaper, PWM ignored
// - shaper output drives dimming split giving 12-bit current and six PWMs
// - current passes compensation, each PWM passes dither before the sinks
// - source 11 multiplies by the brightness level after shaping
package bbc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_BOOST = 8'h00;
  localparam logic [7:0] A_LOOP = 8'h04;
  localparam logic [7:0] A_BRT = 8'h08;
  localparam logic [7:0] A_LEVEL = 8'h0c;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_DUTY = 8'h18;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int F312_KHZ = 312;
  localparam int F625_KHZ = 625;
  localparam int F1250_KHZ = 1250;
  localparam logic [5:0] P312 = 6'(CLK_HZ / (F312_KHZ * 1000));
  localparam logic [5:0] P625 = 6'(CLK_HZ / (F625_KHZ * 1000));
  localparam logic [5:0] P1250 = 6'(CLK_HZ / (F1250_KHZ * 1000));
  localparam int LOOP_US = 100;
  localparam logic [9:0] LOOP_LAST = 10'(LOOP_US * (CLK_HZ / 1_000_000) - 1);
  localparam logic [17:0] PER_MAX = 18'h3ffff;
  localparam logic [4:0] DIV_STEPS = 5'h10;
  localparam logic [11:0] FULL_CUR = 12'hfff;
  // ----------------------------------------------------------------
  // layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic switch_driver_three_on;
    logic switch_driver_two_on;
    logic sw_freq_resistor_sel;
    logic [1:0] sw_freq_code;
    logic adaptive_on;
    logic [5:0] boost_ceiling;
    logic [1:0] boost_floor_range_sel;
    logic [5:0] boost_setpoint_code;
  } bbc_boost_t;
  typedef struct packed {
    logic [5:0] string_enable_pattern;
    logic [3:0] lower_step;
    logic [3:0] raise_step;
    logic [3:0] headroom_hysteresis;
    logic [3:0] sink_headroom_level;
  } bbc_loop_t;
  typedef struct packed {
    logic [11:0] dim_split;
    logic passthrough;
    logic [4:0] spare;
    logic [1:0] brightness_source_sel;
  } bbc_brt_t;
  localparam bbc_boost_t BOOST_RST = 20'hcff08;
  localparam bbc_loop_t LOOP_RST = 22'h3f1224;
  localparam bbc_brt_t BRT_RST = 20'h40000;
  localparam logic [7:0] LEVEL_RST = 8'hff;
endpackage

// file: bbc_core.sv
// Purpose: boost setpoint loop and brightness path of the backlight core
// Assumes: AHB-Lite single word transfers, pwm_in synchronous to hclk
// Notes: configuration writes are ignored while run is set
`timescale 1ns/1ns
module bbc_core import bbc_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pwm_in,
  input wire logic [23:0] sink_level,
  output logic [5:0] boost_level,
  output logic [1:0] boost_range,
  output logic [5:0] sw_period,
  output logic sw_freq_ext,
  output logic [2:0] drv_en,
  output logic [11:0] sink_current,
  output logic [5:0] sink_pwm
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic wr_reg, pend_reg, rdy_reg, run_reg, prev_reg, full_reg, resp_reg;
  logic [7:0] off_reg, brt_reg;
  logic [31:0] rd_reg;
  bbc_boost_t bcfg_reg;
  bbc_loop_t lcfg_reg;
  bbc_brt_t rcfg_reg;
  logic [5:0] level_reg, per_reg, spwm_reg;
  logic [1:0] range_reg;
  logic ext_reg;
  logic [2:0] drv_reg;
  logic [9:0] tick_reg;
  logic [17:0] pcnt_reg, hcnt_reg, den_reg;
  logic [18:0] rem_reg;
  logic [15:0] q_reg, duty_reg, bri_reg;
  logic [4:0] dcnt_reg;
  logic [11:0] cur_reg, fcnt_reg;
  logic [3:0] dacc_reg;
  logic [12:0] thr_reg;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // read view of every register, zero for unmapped offsets
  function automatic logic [31:0] rdmux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      A_BOOST: r = {12'h0, bcfg_reg};
      A_LOOP: r = {10'h0, lcfg_reg};
      A_BRT: r = {12'h0, rcfg_reg};
      A_LEVEL: r = {24'h0, brt_reg};
      A_CTRL: r = {31'h0, run_reg};
      A_STAT: r = {11'h0, run_reg, 1'b0, drv_reg, 1'b0, ext_reg,
                   per_reg, range_reg, level_reg};
      A_DUTY: r = {4'h0, cur_reg, duty_reg};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // scales x by (b+1)/256 so that ff passes x through
  function automatic logic [15:0] scl(input logic [15:0] x, input logic [7:0] b);
    logic [24:0] p;
    p = 25'(x) * 25'({1'b0, b} + 9'h001);
    return p[23:8];
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // a read right behind a write waits one cycle so it sees the new value
  wire logic acc = hsel & htrans[1] & hready;
  wire logic rd_acc = acc & ~hwrite;
  wire logic word = (hsize == 3'h2);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      pend_reg <= 1'b0;
      rdy_reg <= 1'b1;
      off_reg <= 8'h0;
      rd_reg <= 32'h0;
      resp_reg <= 1'b0;
    end else begin
      wr_reg <= acc & hwrite & word;
      pend_reg <= rd_acc & wr_reg;
      rdy_reg <= ~(rd_acc & wr_reg);
      if (acc) off_reg <= haddr[7:0];
      if (rd_acc & ~wr_reg) rd_reg <= rdmux(haddr[7:0]);
      else if (pend_reg) rd_reg <= rdmux(off_reg);
      resp_reg <= 1'b0; // every transfer answers OKAY
    end
  end
  assign hrdata = rd_reg;
  assign hreadyout = rdy_reg;
  assign hresp = resp_reg;

  // write strobes, configuration locked while running
  wire logic wr_b = wr_reg & (off_reg == A_BOOST) & ~run_reg;
  wire logic wr_l = wr_reg & (off_reg == A_LOOP) & ~run_reg;
  wire logic wr_r = wr_reg & (off_reg == A_BRT) & ~run_reg;
  wire logic wr_v = wr_reg & (off_reg == A_LEVEL);
  wire logic wr_c = wr_reg & (off_reg == A_CTRL);

  // configuration and control storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcfg_reg <= BOOST_RST;
      lcfg_reg <= LOOP_RST;
      rcfg_reg <= BRT_RST;
      brt_reg <= LEVEL_RST;
      run_reg <= 1'b0;
    end else begin
      if (wr_b) bcfg_reg <= hwdata[19:0];
      if (wr_l) lcfg_reg <= hwdata[21:0];
      if (wr_r) rcfg_reg <= {hwdata[19:7], 5'h0, hwdata[1:0]};
      if (wr_v) brt_reg <= hwdata[7:0];
      if (wr_c) run_reg <= hwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // boost setpoint loop
  // ----------------------------------------------------------------
  // headroom comparators on enabled strings only
  wire logic [4:0] hi_thr = {1'b0, lcfg_reg.sink_headroom_level} +
                            {1'b0, lcfg_reg.headroom_hysteresis};
  logic [5:0] lo_vec, hi_vec;
  for (genvar i = 0; i < 6; i++) begin : g_cmp
    assign lo_vec[i] = lcfg_reg.string_enable_pattern[i] &
      (sink_level[4*i +: 4] < lcfg_reg.sink_headroom_level);
    assign hi_vec[i] = lcfg_reg.string_enable_pattern[i] &
      ({1'b0, sink_level[4*i +: 4]} > hi_thr);
  end
  wire logic low_any = |lo_vec;
  wire logic high_any = |hi_vec;

  // step arithmetic with floor and ceiling clamps
  wire logic [5:0] ceil = bcfg_reg.boost_ceiling;
  wire logic [5:0] code = bcfg_reg.boost_setpoint_code;
  wire logic [5:0] flr = (code > ceil) ? ceil : code;
  wire logic [6:0] up_sum = {1'b0, level_reg} + {3'h0, lcfg_reg.raise_step};
  wire logic [6:0] dn_dif = {1'b0, level_reg} - {3'h0, lcfg_reg.lower_step};
  wire logic [5:0] up_val = (up_sum > {1'b0, ceil}) ? ceil : up_sum[5:0];
  wire logic [5:0] dn_val = (dn_dif[6] || dn_dif[5:0] < flr) ? flr : dn_dif[5:0];
  wire logic adapt = run_reg & bcfg_reg.adaptive_on;
  wire logic tick = (tick_reg == LOOP_LAST);
  wire logic [5:0] level_next = !adapt ? flr :
                                (tick & low_any) ? up_val :
                                (tick & high_any) ? dn_val :
                                level_reg;

  // switching period in hclk cycles, zero when the resistor sets it
  wire logic [5:0] per_next = bcfg_reg.sw_freq_resistor_sel ? 6'h0 :
                              (bcfg_reg.sw_freq_code == 2'b00) ? P312 :
                              (bcfg_reg.sw_freq_code == 2'b01) ? P625 :
                              (bcfg_reg.sw_freq_code == 2'b10) ? P1250 : 6'h0;

  // loop interval counter and boost outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= 10'h0;
      level_reg <= 6'h0;
      range_reg <= 2'b00;
      per_reg <= 6'h0;
      ext_reg <= 1'b0;
      drv_reg <= 3'b001;
    end else begin
      tick_reg <= (!adapt || tick) ? 10'h0 : tick_reg + 10'h1;
      level_reg <= level_next;
      range_reg <= bcfg_reg.boost_floor_range_sel;
      per_reg <= per_next;
      ext_reg <= bcfg_reg.sw_freq_resistor_sel;
      drv_reg <= {bcfg_reg.switch_driver_three_on,
                  bcfg_reg.switch_driver_two_on, 1'b1};
    end
  end
  assign boost_level = level_reg;
  assign boost_range = range_reg;
  assign sw_period = per_reg;
  assign sw_freq_ext = ext_reg;
  assign drv_en = drv_reg;

  // ----------------------------------------------------------------
  // PWM duty detector
  // ----------------------------------------------------------------
  // period and high time counted from rise to rise, then divided serially
  wire logic rise = pwm_in & ~prev_reg;
  wire logic [18:0] r2 = {rem_reg[17:0], 1'b0};
  wire logic ge = (r2 >= {1'b0, den_reg});
  wire logic [15:0] q_nx = {q_reg[14:0], ge};
  wire logic [18:0] rem_nx = ge ? r2 - {1'b0, den_reg} : r2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
      pcnt_reg <= 18'h0;
      hcnt_reg <= 18'h0;
      den_reg <= 18'h0;
      rem_reg <= 19'h0;
      q_reg <= 16'h0;
      dcnt_reg <= 5'h0;
      duty_reg <= 16'h0;
    end else begin
      prev_reg <= pwm_in;
      if (rise) begin
        pcnt_reg <= 18'h1;
        hcnt_reg <= 18'h1;
        den_reg <= pcnt_reg;
        rem_reg <= {1'b0, hcnt_reg};
        dcnt_reg <= DIV_STEPS;
      end else begin
        if (pcnt_reg != PER_MAX) pcnt_reg <= pcnt_reg + 18'h1;
        if (pwm_in && hcnt_reg != PER_MAX) hcnt_reg <= hcnt_reg + 18'h1;
        if (dcnt_reg != 5'h0) begin
          rem_reg <= rem_nx;
          q_reg <= q_nx;
          dcnt_reg <= dcnt_reg - 5'h1;
        end
      end
      if (!rise && dcnt_reg == 5'h1) duty_reg <= q_nx;
      else if (pcnt_reg == PER_MAX) duty_reg <= {16{pwm_in}};
    end
  end

  // ----------------------------------------------------------------
  // brightness path
  // ----------------------------------------------------------------
  // source select, square-law curve shaper, optional late multiply
  wire logic [1:0] src = rcfg_reg.brightness_source_sel;
  wire logic [15:0] pre = (src == 2'b01) ? scl(duty_reg, brt_reg) :
                          (src == 2'b10) ? {brt_reg, brt_reg} :
                          duty_reg;
  wire logic [31:0] sq = pre * pre;
  wire logic [15:0] post = (src == 2'b11) ? scl(sq[31:16], brt_reg) : sq[31:16];

  // dimming split: PWM below the split point, current above it
  wire logic [11:0] b12 = bri_reg[15:4];
  wire logic below = (b12 < rcfg_reg.dim_split);
  wire logic [11:0] cur_raw = below ? rcfg_reg.dim_split : b12;
  wire logic [4:0] dsum = {1'b0, dacc_reg} + {1'b0, bri_reg[3:0]};
  wire logic fwrap = (fcnt_reg == 12'hfff);
  wire logic pwm_on = full_reg | ({1'b0, fcnt_reg} < thr_reg);

  // non-linear current compensation lifts the mid range
  wire logic [23:0] cp = cur_raw * (FULL_CUR - cur_raw);
  wire logic [12:0] csum = {1'b0, cur_raw} + {2'h0, cp[23:13]};
  wire logic [5:0] pat = lcfg_reg.string_enable_pattern;

  // shaper pipeline, dithered PWM frame and sink outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bri_reg <= 16'h0;
      fcnt_reg <= 12'h0;
      dacc_reg <= 4'h0;
      thr_reg <= 13'h0;
      full_reg <= 1'b0;
      spwm_reg <= 6'h0;
      cur_reg <= 12'h0;
    end else begin
      bri_reg <= post;
      fcnt_reg <= fcnt_reg + 12'h1;
      if (fwrap) begin
        dacc_reg <= dsum[3:0];
        thr_reg <= {1'b0, b12} + {12'h0, dsum[4]};
        full_reg <= ~below;
      end
      if (rcfg_reg.passthrough) begin
        spwm_reg <= pat & {6{pwm_in}};
        cur_reg <= FULL_CUR;
      end else if (run_reg) begin
        spwm_reg <= pat & {6{pwm_on}};
        cur_reg <= csum[11:0];
      end else begin
        spwm_reg <= 6'h0;
        cur_reg <= 12'h0;
      end
    end
  end
  assign sink_pwm = spwm_reg;
  assign sink_current = cur_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_level_ceiling: assert property (
    level_reg <= $past(bcfg_reg.boost_ceiling))
    else $error("setpoint above ceiling");
  a_level_floor: assert property (
    adapt && $past(adapt) |-> level_reg >= flr)
    else $error("setpoint below floor");
  a_step_on_tick: assert property (
    adapt && $past(adapt) && $changed(level_reg) |-> $past(tick))
    else $error("setpoint moved between intervals");
  a_raise_low: assert property (
    adapt && tick && low_any && level_reg < ceil |=> level_reg > $past(level_reg))
    else $error("setpoint not raised");
  a_lower_high: assert property (
    adapt && tick && !low_any && high_any && level_reg > flr
    |=> level_reg < $past(level_reg))
    else $error("setpoint not lowered");
  a_manual_level: assert property (
    !bcfg_reg.adaptive_on && $stable(bcfg_reg) |=> level_reg == $past(flr))
    else $error("manual setpoint wrong");
  a_freq_map: assert property (
    !bcfg_reg.sw_freq_resistor_sel && bcfg_reg.sw_freq_code == 2'b10
    |=> sw_period == P1250)
    else $error("switching period wrong");
  a_driver_map: assert property (
    hresetn |=> drv_en == {$past(bcfg_reg.switch_driver_three_on),
                   $past(bcfg_reg.switch_driver_two_on), 1'b1})
    else $error("driver enables wrong");
  a_direct_pwm: assert property (
    rcfg_reg.passthrough |=> sink_pwm == ($past(pat) & {6{$past(pwm_in)}}))
    else $error("passthrough output wrong");
  a_cfg_locked: assert property (
    run_reg && $past(run_reg) |-> $stable(bcfg_reg) && $stable(lcfg_reg))
    else $error("configuration changed while running");
  a_dark_strings: assert property (
    $stable(pat) |-> (sink_pwm & ~pat) == 6'h0)
    else $error("disabled string driven");
  a_full_pwm: assert property (
    run_reg && !rcfg_reg.passthrough && full_reg |=> sink_pwm == $past(pat))
    else $error("full range output not fully on");
  a_idle_dark: assert property (
    !run_reg && !rcfg_reg.passthrough |=> sink_pwm == 6'h0 && sink_current == 12'h0)
    else $error("sinks driven while stopped");
  a_pass_current: assert property (
    rcfg_reg.passthrough |=> sink_current == FULL_CUR)
    else $error("passthrough current wrong");
endmodule

// file: bbc_host_model.sv
// Purpose: host side model that drives the PWM brightness input
// Assumes: pwm_in is sampled on the rising edge of hclk
// Notes: a high time at or above the period gives a steady high, a high time of 0 a steady low
`timescale 1ns/1ns
module bbc_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] pwm_period,
  input wire logic [15:0] pwm_high,
  output logic pwm_in
);
  logic [15:0] cnt_reg;
  // ----------------------------------------------------------------
  // pwm generator
  // ----------------------------------------------------------------
  // period counter, the output changes just after the edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 16'h0000;
      pwm_in <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg + 16'h0001 >= pwm_period) ? 16'h0000 : cnt_reg + 16'h0001;
      pwm_in <= cnt_reg < pwm_high; // duty the core measures
    end
  end
endmodule

// file: tb_backlight_boost_and_brightness_ctrl.sv
// Purpose: self-checking bench for the backlight core over its register bus
// Assumes: one AHB-Lite master, hready tied to hreadyout
// Notes: PWM from the host model, sink voltages driven directly by the bench
`timescale 1ns/1ns
module tb_backlight_boost_and_brightness_ctrl import bbc_pkg::*; ;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_in, sw_freq_ext;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, boost_range;
  logic [2:0] hsize, drv_en;
  logic [23:0] sink_level;
  logic [5:0] boost_level, sw_period, sink_pwm;
  logic [11:0] sink_current;
  logic [15:0] pwm_period, pwm_high;
  logic [7:0] ra [6] = '{A_BOOST, A_LOOP, A_BRT, A_LEVEL, A_CTRL, 8'h1c};
  logic [31:0] rv [6] = '{32'(BOOST_RST), 32'(LOOP_RST), 32'(BRT_RST), 32'(LEVEL_RST), 0, 0};
  logic [5:0] per [4] = '{6'd32, 6'd16, 6'd8, 6'd0};
  logic [11:0] cur [4] = '{12'h177, 12'h05f, 12'h574, 12'h0bd};
  int bad_count, check_count, cyc_count;

  bbc_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_in(pwm_in),
    .sink_level(sink_level), .boost_level(boost_level), .boost_range(boost_range),
    .sw_period(sw_period), .sw_freq_ext(sw_freq_ext), .drv_en(drv_en),
    .sink_current(sink_current), .sink_pwm(sink_pwm));
  bbc_host_model host_u (.hclk(hclk), .hresetn(hresetn), .pwm_period(pwm_period),
    .pwm_high(pwm_high), .pwm_in(pwm_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single transfer: address phase, then data phase, each held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'h2, rd);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 3'h2, rd);
    check(what, rd, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic [31:0] bo(input logic [5:0] l, input logic [1:0] r,
                                     input logic [5:0] p, input logic e, input logic [2:0] d);
    return {14'h0000, l, r, p, e, d};
  endfunction
  // waits up to 1200 cycles, a little over one loop interval, for the setpoint to move, then compares
  task automatic wait_boost(input logic [5:0] exp);
    logic [5:0] old;
    int n;
    old = boost_level;
    n = 0;
    while (boost_level === old && n < 1200) begin
      @(posedge hclk);
      n++;
    end
    check("boost_level", {26'h0, boost_level}, {26'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sink_level = 24'h000000;
    pwm_period = 16'h0040;
    pwm_high = 16'h0010;
    bad_count = 0;
    check_count = 0;
    cyc_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    // reset outputs and register values, unmapped place reads 0
    check("boost_rst", bo(boost_level, boost_range, sw_period, sw_freq_ext, drv_en),
          bo(6'd8, 2'd0, 6'd16, 1'b0, 3'b111));
    check("hresp", {31'h0, hresp}, 32'h0);
    for (int i = 0; i < 6; i++) rdchk("reg_rst", ra[i], rv[i]);
    // each frequency code paired with one driver combination, manual setpoint
    for (int i = 0; i < 4; i++) begin
      wr(A_BOOST, 32'h3f4a | (32'(i) << 15) | (32'(i & 1) << 18) | (32'(i >> 1) << 19));
      cyc(3);
      check("freq_drv", bo(boost_level, boost_range, sw_period, sw_freq_ext, drv_en),
            bo(6'd10, 2'd1, per[i], 1'b0, {i[1], i[0], 1'b1}));
    end
    wr(A_BOOST, 32'h2bf4a);
    cyc(3);
    check("freq_res", bo(boost_level, boost_range, sw_period, sw_freq_ext, drv_en),
          bo(6'd10, 2'd1, 6'd0, 1'b1, 3'b001));
    wr(A_BOOST, 32'h0fd4);
    cyc(3);
    check("manual_clamp", bo(boost_level, boost_range, sw_period, sw_freq_ext, drv_en),
          bo(6'd15, 2'd3, 6'd32, 1'b0, 3'b001));
    // host brightness level, narrow write and unmapped write refused
    wr(A_LEVEL, 32'h7f);
    xfer(1'b1, A_LEVEL, 32'h11, 3'h0, rd);
    rdchk("level_narrow", A_LEVEL, 32'h7f);
    wr(8'h1c, 32'hffffffff);
    rdchk("unmapped", 8'h1c, 32'h0);
    // measured duty of a 16 of 64 pulse
    cyc(200);
    xfer(1'b0, A_DUTY, 32'h0, 3'h2, rd);
    check("duty", {16'h0, rd[15:0]}, 32'h4000);
    // each source mode with split 0, so current follows the shaped value
    wr(A_LOOP, 32'h252335);
    // split 0 must meet a frame boundary before the PWM runs full
    wr(A_BRT, 32'h0);
    cyc(4100);
    for (int s = 0; s < 4; s++) begin
      wr(A_CTRL, 32'h0);
      wr(A_BRT, 32'(s));
      cyc(3);
      check("idle_sinks", {20'h0, sink_pwm, sink_current[5:0]}, 32'h0);
      check("idle_cur", {20'h0, sink_current}, 32'h0);
      wr(A_CTRL, 32'h1);
      cyc(200);
      check("src_cur", {20'h0, sink_current}, {20'h0, cur[s]});
      check("src_pwm", {26'h0, sink_pwm}, 32'h25);
    end
    // passthrough follows the PWM pin whatever the source
    wr(A_CTRL, 32'h0);
    wr(A_BRT, 32'h83);
    pwm_high <= 16'hffff;
    cyc(70);
    check("pass_hi", {14'h0, sink_pwm, sink_current}, {14'h0, 6'h25, 12'hfff});
    pwm_high <= 16'h0000;
    cyc(5);
    check("pass_lo", {26'h0, sink_pwm}, 32'h0);
    // adaptive loop: raise, clamp at ceiling, lower, stop at floor
    wr(A_BRT, 32'h0);
    wr(A_BOOST, 32'h54e8a);
    wr(A_LOOP, 32'h32335);
    sink_level <= 24'h000044;
    cyc(3);
    check("adapt_cfg", bo(boost_level, boost_range, sw_period, sw_freq_ext, drv_en),
          bo(6'd10, 2'd2, 6'd8, 1'b0, 3'b011));
    wr(A_CTRL, 32'h1);
    wait_boost(6'd13);
    wait_boost(6'd14);
    sink_level <= 24'h0000aa;
    wait_boost(6'd12);
    wait_boost(6'd10);
    wait_boost(6'd10);
    wr(A_BOOST, 32'h0);
    rdchk("cfg_locked", A_BOOST, 32'h54e8a);
    // adaptive bit clear: low strings no longer raise the setpoint
    wr(A_CTRL, 32'h0);
    wr(A_BOOST, 32'h50e8a);
    sink_level <= 24'h000044;
    wr(A_CTRL, 32'h1);
    wait_boost(6'd10);
    report_and_stop();
  end
endmodule
